// ### design/afc_config_regs.sv
`timescale 1ns/10ps
// Contract
// (R1) Input select bit 0 set routes analog input 1 to the first ADC.
// (R2) Input select bit 1 set routes analog input 1 to the second ADC.
// (R3) Input select bits 2 and 3 each select input 2 for ADC2.
// (R4) Input select bits 4 and 5 each select input 3 for ADC2.
// (R5) Input select bit 6: ADC1 differential at 0, single-ended at 1.
// (R6) Input select bit 7: ADC2 differential at 0, single-ended at 1.
// (R7) Matching bit 0: element matching enabled at 0, disabled at 1.
// (R8) Matching bit 1: weighted averaging enabled at 0, disabled at 1.
// (R9) Matching bit 3: fast reference charge at 0, slow filtered charge at 1.
// (R10) Bias bits 1:0 set ADC2 summer: 130, 100, 100, 70 percent.
// (R11) Bias bits 3:2 set ADC2 quantizer: 137.5, 100, 100, 62.5 percent.
// (R12) Bias bits 5:4 set ADC2 third integrator: 130, 100, 100, 70 percent.
// (R13) Bias bits 7:6 set ADC2 reference buffer: 130, 100, 100, 70 percent.
// (R14) Matching bits 2 and 7:4 store and read back but drive nothing.
// (R15) Registers hold the last write and drive outputs continuously.
// (R16) Reads return the held value with no side effect.
module afc_config_regs (
    input  wire logic                              MCLK_IN,
    input  wire logic                              RST_IN,
    input  wire logic                              PSEL_IN,
    input  wire logic                              PENABLE_IN,
    input  wire logic                              PWRITE_IN,
    input  wire logic [11:0]                       PADDR_IN,
    input  wire logic [31:0]                       PWDATA_IN,
    input  wire logic [3:0]                        PSTRB_IN,
    output logic      [31:0]                       PRDATA_OUT,
    output logic                                   PREADY_OUT,
    output logic                                   PSLVERR_OUT,
    output afc_pkg::afc_input_sel_type             INPUT_SEL_OUT,
    output afc_pkg::afc_elem_match_type            ELEM_MATCH_OUT,
    output afc_pkg::afc_bias_code_type             BIAS_CODE_OUT,
    output afc_pkg::afc_bias_level_type [3:0]      BIAS_LEVEL_OUT
);
    import afc_pkg::*;

    localparam logic [7:0] REG_IDX [AFC_NUM_REGS] = '{AFC_IDX_INPUT_SEL, AFC_IDX_ELEM_MATCH, AFC_IDX_BIAS_SEL};
    localparam logic [7:0] REG_RST [AFC_NUM_REGS] = '{AFC_RST_INPUT_SEL, AFC_RST_ELEM_MATCH, AFC_RST_BIAS_SEL};

    logic                     pready_ff;
    logic                     pslverr_ff;
    logic [31:0]              prdata_ff;
    logic                     nxt_pready;
    logic                     nxt_pslverr;
    logic [31:0]              nxt_prdata;
    logic                     setup_phase;
    logic                     access_done;
    logic                     addr_aligned;
    logic [AFC_NUM_REGS-1:0]  reg_hit;
    logic [AFC_NUM_REGS-1:0]  reg_we;
    logic                     addr_mapped;
    logic                     lane0_wr;
    logic [7:0]               reg_q [AFC_NUM_REGS];
    logic [7:0]               rd_byte;
    afc_bias_code_type        bias_code;

    // Bus phase decode
    assign setup_phase  = PSEL_IN & ~PENABLE_IN;
    assign access_done  = PSEL_IN & PENABLE_IN & pready_ff;
    assign addr_aligned = (PADDR_IN[1:0] == 2'h0);
    assign addr_mapped  = |reg_hit;
    assign lane0_wr     = PWRITE_IN & PSTRB_IN[0];

    // Per-register address match, write strobe and storage
    genvar gi;
    generate
        for (gi = 0; gi < AFC_NUM_REGS; gi++) begin : g_reg
            assign reg_hit[gi] = addr_aligned & (PADDR_IN[11:2] == {2'h0, REG_IDX[gi]});
            assign reg_we[gi]  = access_done & reg_hit[gi] & lane0_wr; // [R15]
            afc_reg8 #(
                .RESET_VAL (REG_RST[gi])
            ) u_reg (
                .clk_in   (MCLK_IN),
                .rst_in   (RST_IN),
                .we_in    (reg_we[gi]),
                .wdata_in (PWDATA_IN[7:0]),
                .q_out    (reg_q[gi])
            );
        end
    endgenerate

    // Read select; all eight bits read back, unused ones too
    assign rd_byte = reg_hit[0] ? reg_q[0] :
                     reg_hit[1] ? reg_q[1] :
                     reg_hit[2] ? reg_q[2] : 8'h00; // [R14] [R16]

    // Answer one cycle after setup, zero wait states
    assign nxt_pready  = setup_phase;
    assign nxt_pslverr = setup_phase & ~addr_mapped;
    assign nxt_prdata  = (setup_phase & ~PWRITE_IN & addr_mapped) ? {24'h000000, rd_byte} : 32'h00000000; // [R16]

    // Bus answer registers
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    assign PREADY_OUT  = pready_ff;
    assign PSLVERR_OUT = pslverr_ff;
    assign PRDATA_OUT  = prdata_ff;

    // Mux routing and input mode straight from the stored byte
    assign INPUT_SEL_OUT = afc_input_sel_type'(reg_q[0]); // [R1] [R2] [R3] [R4] [R5] [R6]

    // Only bits 3, 1 and 0 reach the analog side
    assign ELEM_MATCH_OUT.dem_disable = reg_q[1][AFC_BIT_DEM_DIS];  // [R7]
    assign ELEM_MATCH_OUT.dwa_disable = reg_q[1][AFC_BIT_DWA_DIS];  // [R8]
    assign ELEM_MATCH_OUT.vref_slow   = reg_q[1][AFC_BIT_VREF_SLOW]; // [R9] [R14]

    // Bias trim codes and their decoded levels
    assign bias_code     = afc_bias_code_type'(reg_q[2]);
    assign BIAS_CODE_OUT = bias_code; // [R10] [R11] [R12] [R13]

    genvar bi;
    generate
        for (bi = 0; bi < AFC_BIAS_FIELDS; bi++) begin : g_bias
            afc_bias_dec u_dec (
                .clk_in    (MCLK_IN),
                .rst_in    (RST_IN),
                .code_in   (reg_q[2][bi*AFC_BIAS_W +: AFC_BIAS_W]), // [R10] [R11] [R12] [R13]
                .level_out (BIAS_LEVEL_OUT[bi])
            );
        end
    endgenerate

    // Checks on the register behaviour
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    property p_in1_adc1;
        reg_we[0] |=> INPUT_SEL_OUT.in1_adc1 == $past(PWDATA_IN[0]);
    endproperty
    a_in1_adc1: assert property (p_in1_adc1) else $error("input 1 to ADC1 wrong"); // [R1]

    property p_in1_adc2;
        reg_we[0] |=> INPUT_SEL_OUT.in1_adc2 == $past(PWDATA_IN[1]);
    endproperty
    a_in1_adc2: assert property (p_in1_adc2) else $error("input 1 to ADC2 wrong"); // [R2]

    property p_in2_adc2;
        reg_we[0] |=> {INPUT_SEL_OUT.in2_adc2_b, INPUT_SEL_OUT.in2_adc2_a} == $past(PWDATA_IN[3:2]);
    endproperty
    a_in2_adc2: assert property (p_in2_adc2) else $error("input 2 to ADC2 wrong"); // [R3]

    property p_in3_adc2;
        reg_we[0] |=> {INPUT_SEL_OUT.in3_adc2_b, INPUT_SEL_OUT.in3_adc2_a} == $past(PWDATA_IN[5:4]);
    endproperty
    a_in3_adc2: assert property (p_in3_adc2) else $error("input 3 to ADC2 wrong"); // [R4]

    property p_adc1_mode;
        reg_we[0] |=> INPUT_SEL_OUT.adc1_single == $past(PWDATA_IN[6]);
    endproperty
    a_adc1_mode: assert property (p_adc1_mode) else $error("ADC1 input mode wrong"); // [R5]

    property p_adc2_mode;
        reg_we[0] |=> INPUT_SEL_OUT.adc2_single == $past(PWDATA_IN[7]);
    endproperty
    a_adc2_mode: assert property (p_adc2_mode) else $error("ADC2 input mode wrong"); // [R6]

    property p_dem;
        reg_we[1] |=> ELEM_MATCH_OUT.dem_disable == $past(PWDATA_IN[0]);
    endproperty
    a_dem: assert property (p_dem) else $error("element matching control wrong"); // [R7]

    property p_dwa;
        reg_we[1] |=> ELEM_MATCH_OUT.dwa_disable == $past(PWDATA_IN[1]);
    endproperty
    a_dwa: assert property (p_dwa) else $error("weighted averaging control wrong"); // [R8]

    property p_vref;
        reg_we[1] |=> ELEM_MATCH_OUT.vref_slow == $past(PWDATA_IN[3]);
    endproperty
    a_vref: assert property (p_vref) else $error("reference charge mode wrong"); // [R9]

    property p_summer_low;
        reg_we[2] && PWDATA_IN[1:0] == AFC_CODE_REDUCED |-> ##2 BIAS_LEVEL_OUT[0] == AFC_LVL_REDUCED;
    endproperty
    a_summer_low: assert property (p_summer_low) else $error("summer bias level wrong"); // [R10]

    property p_quant_boost;
        reg_we[2] && PWDATA_IN[3:2] == AFC_CODE_BOOST |-> ##2 BIAS_LEVEL_OUT[1] == AFC_LVL_BOOST;
    endproperty
    a_quant_boost: assert property (p_quant_boost) else $error("quantizer bias level wrong"); // [R11]

    property p_int3_nom;
        reg_we[2] && (PWDATA_IN[5:4] == AFC_CODE_NOM_A || PWDATA_IN[5:4] == AFC_CODE_NOM_B)
            |-> ##2 BIAS_LEVEL_OUT[2] == AFC_LVL_NOMINAL;
    endproperty
    a_int3_nom: assert property (p_int3_nom) else $error("third integrator bias level wrong"); // [R12]

    property p_refbuf;
        reg_we[2] |=> BIAS_CODE_OUT.ref_buf == $past(PWDATA_IN[7:6]) ##1
            BIAS_LEVEL_OUT[3] == (($past(PWDATA_IN[7:6], 2) == AFC_CODE_BOOST) ? AFC_LVL_BOOST :
                                  ($past(PWDATA_IN[7:6], 2) == AFC_CODE_REDUCED) ? AFC_LVL_REDUCED :
                                  AFC_LVL_NOMINAL);
    endproperty
    a_refbuf: assert property (p_refbuf) else $error("reference buffer bias wrong"); // [R13]

    property p_unused_bits;
        reg_we[1] && PWDATA_IN[3] == ELEM_MATCH_OUT.vref_slow && PWDATA_IN[1] == ELEM_MATCH_OUT.dwa_disable
            && PWDATA_IN[0] == ELEM_MATCH_OUT.dem_disable |=> $stable(ELEM_MATCH_OUT);
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused bit reached analog side"); // [R14]

    property p_hold;
        !(|reg_we) |=> $stable(INPUT_SEL_OUT) && $stable(ELEM_MATCH_OUT) && $stable(BIAS_CODE_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("control changed without a write"); // [R15]

    property p_read_data;
        setup_phase && !PWRITE_IN && reg_hit[2] |=> PREADY_OUT && !PSLVERR_OUT
            && PRDATA_OUT == {24'h000000, BIAS_CODE_OUT} ##1 !PREADY_OUT;
    endproperty
    a_read_data: assert property (p_read_data) else $error("read answer wrong"); // [R16]

    property p_unmapped;
        setup_phase && !addr_mapped |=> PREADY_OUT && PSLVERR_OUT && PRDATA_OUT == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    // Answer timing: zero wait states, one-cycle pulses
    property p_ready_time;
        setup_phase |=> PREADY_OUT;
    endproperty
    a_ready_time: assert property (p_ready_time) else $error("answer late");

    property p_ready_pulse;
        PREADY_OUT && PENABLE_IN |=> !PREADY_OUT;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    property p_err_mapped;
        setup_phase && addr_mapped |=> !PSLVERR_OUT;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("error on mapped address");

    property p_rdata_idle;
        !PREADY_OUT |-> PRDATA_OUT == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

    property p_write_answer;
        setup_phase && PWRITE_IN |=> PRDATA_OUT == 32'h00000000;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("read data on write");

    // Read-back of the other two registers
    property p_read_input;
        setup_phase && !PWRITE_IN && reg_hit[0] |=> PRDATA_OUT == {24'h000000, INPUT_SEL_OUT};
    endproperty
    a_read_input: assert property (p_read_input) else $error("input select read wrong"); // [R16]

    property p_read_match;
        setup_phase && !PWRITE_IN && reg_hit[1] |=> PRDATA_OUT[31:8] == 24'h000000
            && PRDATA_OUT[3] == ELEM_MATCH_OUT.vref_slow && PRDATA_OUT[1] == ELEM_MATCH_OUT.dwa_disable
            && PRDATA_OUT[0] == ELEM_MATCH_OUT.dem_disable;
    endproperty
    a_read_match: assert property (p_read_match) else $error("matching read wrong"); // [R16]

    property p_unused_stored;
        reg_we[1] |=> reg_q[1] == $past(PWDATA_IN[7:0]);
    endproperty
    a_unused_stored: assert property (p_unused_stored) else $error("matching byte not stored"); // [R14]

    // Reads, refused and masked writes leave the controls alone
    property p_read_no_effect;
        PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
            |=> $stable(INPUT_SEL_OUT) && $stable(ELEM_MATCH_OUT) && $stable(BIAS_CODE_OUT);
    endproperty
    a_read_no_effect: assert property (p_read_no_effect) else $error("read changed a control"); // [R16]

    property p_refused_write;
        PSEL_IN && PENABLE_IN && PSLVERR_OUT
            |=> $stable(INPUT_SEL_OUT) && $stable(ELEM_MATCH_OUT) && $stable(BIAS_CODE_OUT);
    endproperty
    a_refused_write: assert property (p_refused_write) else $error("refused access changed a control");

    property p_masked_write;
        PSEL_IN && PENABLE_IN && PREADY_OUT && !PSTRB_IN[0]
            |=> $stable(INPUT_SEL_OUT) && $stable(ELEM_MATCH_OUT) && $stable(BIAS_CODE_OUT);
    endproperty
    a_masked_write: assert property (p_masked_write) else $error("masked write changed a control"); // [R15]

    // Trim codes, and their levels two edges after the write
    property p_bias_code;
        reg_we[2] |=> BIAS_CODE_OUT.summer == $past(PWDATA_IN[1:0])
            && BIAS_CODE_OUT.quantizer == $past(PWDATA_IN[3:2])
            && BIAS_CODE_OUT.third_int == $past(PWDATA_IN[5:4]);
    endproperty
    a_bias_code: assert property (p_bias_code) else $error("bias code not stored"); // [R10] [R11] [R12]

    property p_summer_boost;
        reg_we[2] && PWDATA_IN[1:0] == AFC_CODE_BOOST |-> ##2 BIAS_LEVEL_OUT[0] == AFC_LVL_BOOST;
    endproperty
    a_summer_boost: assert property (p_summer_boost) else $error("summer boost wrong"); // [R10]

    property p_summer_nom;
        reg_we[2] && (PWDATA_IN[1:0] == AFC_CODE_NOM_A || PWDATA_IN[1:0] == AFC_CODE_NOM_B)
            |-> ##2 BIAS_LEVEL_OUT[0] == AFC_LVL_NOMINAL;
    endproperty
    a_summer_nom: assert property (p_summer_nom) else $error("summer nominal wrong"); // [R10]

    property p_quant_low;
        reg_we[2] && PWDATA_IN[3:2] == AFC_CODE_REDUCED |-> ##2 BIAS_LEVEL_OUT[1] == AFC_LVL_REDUCED;
    endproperty
    a_quant_low: assert property (p_quant_low) else $error("quantizer reduced wrong"); // [R11]

    property p_quant_nom;
        reg_we[2] && (PWDATA_IN[3:2] == AFC_CODE_NOM_A || PWDATA_IN[3:2] == AFC_CODE_NOM_B)
            |-> ##2 BIAS_LEVEL_OUT[1] == AFC_LVL_NOMINAL;
    endproperty
    a_quant_nom: assert property (p_quant_nom) else $error("quantizer nominal wrong"); // [R11]

    property p_int3_boost;
        reg_we[2] && PWDATA_IN[5:4] == AFC_CODE_BOOST |-> ##2 BIAS_LEVEL_OUT[2] == AFC_LVL_BOOST;
    endproperty
    a_int3_boost: assert property (p_int3_boost) else $error("integrator boost wrong"); // [R12]

    property p_int3_low;
        reg_we[2] && PWDATA_IN[5:4] == AFC_CODE_REDUCED |-> ##2 BIAS_LEVEL_OUT[2] == AFC_LVL_REDUCED;
    endproperty
    a_int3_low: assert property (p_int3_low) else $error("integrator reduced wrong"); // [R12]

    // Controls leave reset at their defaults; code 00 decodes to boost
    property p_reset_vals;
        $fell(RST_IN) |-> INPUT_SEL_OUT == AFC_RST_INPUT_SEL && BIAS_CODE_OUT == AFC_RST_BIAS_SEL
            && BIAS_LEVEL_OUT[0] == AFC_LVL_BOOST && !PREADY_OUT;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong"); // [R15]

    c_write_input: cover property (reg_we[0] ##1 INPUT_SEL_OUT.in1_adc1);
    c_read_bias: cover property (setup_phase && !PWRITE_IN && reg_hit[2] ##1 PREADY_OUT);
    c_unmapped: cover property (PREADY_OUT && PSLVERR_OUT);
    c_slow_vref: cover property ($rose(ELEM_MATCH_OUT.vref_slow));

endmodule

// ### design/afc_pkg.sv
package afc_pkg;

    // Register indices as numbered in the map; byte address is index * 4
    localparam int            AFC_NUM_REGS = 3;
    localparam logic [7:0]    AFC_IDX_INPUT_SEL  = 8'h12;
    localparam logic [7:0]    AFC_IDX_ELEM_MATCH = 8'h13;
    localparam logic [7:0]    AFC_IDX_BIAS_SEL   = 8'h14;
    localparam logic [11:0]   AFC_ADDR_INPUT_SEL  = 12'h048;
    localparam logic [11:0]   AFC_ADDR_ELEM_MATCH = 12'h04C;
    localparam logic [11:0]   AFC_ADDR_BIAS_SEL   = 12'h050;

    // Reset values: recommended startup settings
    localparam logic [7:0]    AFC_RST_INPUT_SEL  = 8'h00;
    localparam logic [7:0]    AFC_RST_ELEM_MATCH = 8'h00;
    localparam logic [7:0]    AFC_RST_BIAS_SEL   = 8'h00;

    // Element matching field positions
    localparam int            AFC_BIT_DEM_DIS    = 0;
    localparam int            AFC_BIT_DWA_DIS    = 1;
    localparam int            AFC_BIT_VREF_SLOW  = 3;

    // Bias field width and trim codes
    localparam int            AFC_BIAS_FIELDS    = 4;
    localparam int            AFC_BIAS_W         = 2;
    localparam logic [1:0]    AFC_CODE_BOOST     = 2'h0;
    localparam logic [1:0]    AFC_CODE_NOM_A     = 2'h1;
    localparam logic [1:0]    AFC_CODE_NOM_B     = 2'h2;
    localparam logic [1:0]    AFC_CODE_REDUCED   = 2'h3;

    // Bus answer latency after the setup cycle, in wait states
    localparam int            AFC_APB_WAIT       = 0;

    // Bias level: boost is 130 % (137.5 % for quantizer), reduced 70 % (62.5 %)
    typedef enum logic [1:0] {
        AFC_LVL_BOOST,
        AFC_LVL_NOMINAL,
        AFC_LVL_REDUCED
    } afc_bias_level_type;

    typedef struct packed {
        logic adc2_single;
        logic adc1_single;
        logic in3_adc2_b;
        logic in3_adc2_a;
        logic in2_adc2_b;
        logic in2_adc2_a;
        logic in1_adc2;
        logic in1_adc1;
    } afc_input_sel_type;

    typedef struct packed {
        logic vref_slow;
        logic dwa_disable;
        logic dem_disable;
    } afc_elem_match_type;

    typedef struct packed {
        logic [1:0] ref_buf;
        logic [1:0] third_int;
        logic [1:0] quantizer;
        logic [1:0] summer;
    } afc_bias_code_type;

endpackage

// ### design/afc_reg8.sv
`timescale 1ns/10ps
module afc_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        we_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  q_out
);
    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    // Hold until rewritten
    assign nxt_q = we_in ? wdata_in : q_ff;
    assign q_out = q_ff;

    // Storage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_ff <= RESET_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule

// ### design/afc_bias_dec.sv
`timescale 1ns/10ps
module afc_bias_dec (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic [1:0]                  code_in,
    output afc_pkg::afc_bias_level_type      level_out
);
    import afc_pkg::*;

    afc_bias_level_type level_ff;
    afc_bias_level_type nxt_level;

    // Both middle codes map to nominal current
    assign nxt_level = (code_in == AFC_CODE_BOOST)   ? AFC_LVL_BOOST :
                       (code_in == AFC_CODE_REDUCED) ? AFC_LVL_REDUCED : AFC_LVL_NOMINAL;
    assign level_out = level_ff;

    // Registered level
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_ff <= AFC_LVL_BOOST;
        end else begin
            level_ff <= nxt_level;
        end
    end
endmodule

// ### verif/afc_analog_model.sv
`timescale 1ns/10ps
module afc_analog_model (
    input  wire afc_pkg::afc_input_sel_type         sel_in,
    input  wire afc_pkg::afc_elem_match_type        em_in,
    input  wire afc_pkg::afc_bias_level_type [3:0]  lvl_in,
    output logic                                    adc1_in1_out,
    output logic      [2:0]                         adc2_src_out,
    output logic      [1:0]                         single_out,
    output logic                                    dem_on_out,
    output logic                                    dwa_on_out,
    output logic                                    vref_filter_out,
    output logic      [3:0][10:0]                   pct_out
);
    import afc_pkg::*;

    // Multiplexer routing and input mode
    assign adc1_in1_out    = sel_in.in1_adc1;
    assign adc2_src_out[0] = sel_in.in1_adc2;
    assign adc2_src_out[1] = sel_in.in2_adc2_a | sel_in.in2_adc2_b;
    assign adc2_src_out[2] = sel_in.in3_adc2_a | sel_in.in3_adc2_b;
    assign single_out      = {sel_in.adc2_single, sel_in.adc1_single};

    // Modulator options; unused matching bits never reach here
    assign dem_on_out      = ~em_in.dem_disable;
    assign dwa_on_out      = ~em_in.dwa_disable;
    assign vref_filter_out = em_in.vref_slow;

    // Bias current in tenths of a percent; index 1 is the quantizer
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            case (lvl_in[i])
                AFC_LVL_BOOST:   pct_out[i] = (i == 1) ? 11'h55F : 11'h514;
                AFC_LVL_REDUCED: pct_out[i] = (i == 1) ? 11'h271 : 11'h2BC;
                default:         pct_out[i] = 11'h3E8;
            endcase
        end
    end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import afc_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        err;
    } afc_row_type;

    localparam afc_row_type ROWS [20] = '{
        '{12'h048, 8'h01, 1'h0}, '{12'h048, 8'h02, 1'h0}, '{12'h048, 8'h0C, 1'h0}, '{12'h048, 8'h30, 1'h0},
        '{12'h048, 8'h40, 1'h0}, '{12'h048, 8'h80, 1'h0}, '{12'h048, 8'hA5, 1'h0}, '{12'h04C, 8'h01, 1'h0},
        '{12'h04C, 8'h02, 1'h0}, '{12'h04C, 8'h08, 1'h0}, '{12'h04C, 8'hF4, 1'h0}, '{12'h04C, 8'h0B, 1'h0},
        '{12'h04C, 8'hFB, 1'h0}, '{12'h050, 8'h1B, 1'h0}, '{12'h050, 8'hE4, 1'h0}, '{12'h050, 8'hFF, 1'h0},
        '{12'h050, 8'h96, 1'h0}, '{12'h050, 8'h41, 1'h0}, '{12'h054, 8'h5A, 1'h1}, '{12'h049, 8'h33, 1'h1}};

    logic                     mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata;
    logic [3:0]               pstrb;
    afc_input_sel_type        input_sel;
    afc_elem_match_type       elem_match;
    afc_bias_code_type        bias_code;
    afc_bias_level_type [3:0] bias_level;
    logic [2:0]               adc2_src;
    logic [3:0][10:0]         pct;
    logic                     adc1_in1, dem_on, dwa_on, vref_filt;
    logic [1:0]               in_mode;
    logic [7:0]               shadow [3];
    int                       err_count = 0, checked = 0, cycles = 0;

    afc_config_regs dut_u (
        .MCLK_IN(mclk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .INPUT_SEL_OUT(input_sel), .ELEM_MATCH_OUT(elem_match),
        .BIAS_CODE_OUT(bias_code), .BIAS_LEVEL_OUT(bias_level));

    afc_analog_model model_u (
        .sel_in(input_sel), .em_in(elem_match), .lvl_in(bias_level), .adc1_in1_out(adc1_in1),
        .adc2_src_out(adc2_src), .single_out(in_mode), .dem_on_out(dem_on), .dwa_on_out(dwa_on),
        .vref_filter_out(vref_filt), .pct_out(pct));

    // Clock at 125 MHz
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    function automatic afc_bias_level_type exp_lvl(input logic [1:0] c);
        return (c == 2'h0) ? AFC_LVL_BOOST : (c == 2'h3) ? AFC_LVL_REDUCED : AFC_LVL_NOMINAL;
    endfunction

    function automatic logic [10:0] exp_pct(input int i, input logic [1:0] c);
        if (c == 2'h0) return (i == 1) ? 11'h55F : 11'h514;
        if (c == 2'h3) return (i == 1) ? 11'h271 : 11'h2BC;
        return 11'h3E8;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request stays up after the sampling edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'hA5A5A5, d};
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
    endtask

    task automatic idle();
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic check_outs();
        chk(32'(input_sel), 32'(shadow[0]));
        chk(32'(adc2_src), 32'({shadow[0][5] | shadow[0][4], shadow[0][3] | shadow[0][2], shadow[0][1]}));
        chk(32'(adc1_in1), 32'(shadow[0][0]));
        chk(32'(in_mode), 32'(shadow[0][7:6]));
        chk(32'({dem_on, dwa_on, vref_filt}), 32'({~shadow[1][0], ~shadow[1][1], shadow[1][3]}));
        chk(32'(elem_match), 32'({shadow[1][3], shadow[1][1:0]}));
        chk(32'(bias_code), 32'(shadow[2]));
        for (int i = 0; i < 4; i++) begin
            chk(32'(bias_level[i]), 32'(exp_lvl(shadow[2][2*i+:2])));
            chk(32'(pct[i]), 32'(exp_pct(i, shadow[2][2*i+:2])));
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] rd;
        logic        er;
        int          k;
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        shadow = '{8'h00, 8'h00, 8'h00};
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        check_outs();
        // Table: write, read back at once, then outputs
        foreach (ROWS[i]) begin
            k = int'((ROWS[i].addr - AFC_ADDR_INPUT_SEL) >> 2);
            apb(1'h1, ROWS[i].addr, ROWS[i].wdata, 4'hF, rd, er);
            chk(32'(er), 32'(ROWS[i].err));
            if (!ROWS[i].err) shadow[k] = ROWS[i].wdata;
            apb(1'h0, ROWS[i].addr, 8'h00, 4'h0, rd, er);
            chk(rd, ROWS[i].err ? 32'h0 : {24'h0, shadow[k]});
            idle();
            check_outs();
        end
        // Write with the low lane strobe off is dropped
        apb(1'h1, AFC_ADDR_BIAS_SEL, 8'h3C, 4'hE, rd, er);
        chk(32'(er), 32'h0);
        idle();
        check_outs();
        // Back-to-back writes to all three
        apb(1'h1, AFC_ADDR_INPUT_SEL, 8'h5A, 4'h1, rd, er);
        apb(1'h1, AFC_ADDR_ELEM_MATCH, 8'h09, 4'h1, rd, er);
        apb(1'h1, AFC_ADDR_BIAS_SEL, 8'hC3, 4'h1, rd, er);
        shadow = '{8'h5A, 8'h09, 8'hC3};
        idle();
        // Decoded levels lag the stored code by one edge
        @(posedge mclk);
        check_outs();
        // Reset in mid-run clears everything
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        shadow = '{8'h00, 8'h00, 8'h00};
        @(posedge mclk);
        check_outs();
        // First transfer right after release
        apb(1'h0, AFC_ADDR_BIAS_SEL, 8'h00, 4'h0, rd, er);
        chk(rd, {24'h000000, AFC_RST_BIAS_SEL});
        idle();
        end_of_test();
    end
endmodule
